// file: design/jle_pkg.sv
// jle_pkg: shared types and constants of the jump and level exit unit.
// assumes a 16-bit word machine with four interrupt levels.
package jle_pkg;
	localparam int JLE_LEVELS = 4;
	localparam int JLE_AW = 16;
	localparam logic [2:0] JLE_CC_ZERO = 3'h0;
	localparam logic [2:0] JLE_CC_POS = 3'h1;
	localparam logic [2:0] JLE_CC_NEG = 3'h2;
	localparam logic [2:0] JLE_CC_EVEN = 3'h3;
	localparam logic [2:0] JLE_CC_ALT = 3'h4;
	localparam logic [2:0] JLE_CC_ALE = 3'h5;
	localparam logic [2:0] JLE_CC_LLE = 3'h6;
	localparam logic [2:0] JLE_CC_CARRY = 3'h7;
	localparam int JLE_LSR_INPROC_BIT = 9;
	localparam int JLE_LSR_SUMMARY_BIT = 11;
	localparam logic [15:0] JLE_RESET_IAR = 16'h0000;

	typedef enum logic [1:0]
	{
		JLE_OP_JUMP_IF_CONDITION = 2'h0,
		JLE_OP_JUMP_IF_NOT_CONDITION = 2'h1,
		JLE_OP_COUNT_AND_JUMP = 2'h2,
		JLE_OP_LEAVE_CURRENT_LEVEL = 2'h3
	} jle_op_t;

	typedef struct packed
	{
		jle_op_t op;
		logic [2:0] cond;
		logic [2:0] reg_sel;
		logic [7:0] disp;
	} jle_instr_t;

	typedef struct packed
	{
		logic even;
		logic carry;
		logic overflow;
		logic negative;
		logic zero;
	} jle_ind_t;

	typedef struct packed
	{
		logic [JLE_LEVELS-1:0] pending;
		logic [JLE_LEVELS-1:0] request;
		logic [JLE_LEVELS-1:0] level_mask;
		logic [1:0] current;
	} jle_lvl_t;
endpackage

// file: design/jle_unit.sv
// jle_unit: executes conditional jumps, count-and-jump and level exit.
// assumes the decoder holds EXEC_INSTR with EXEC_VALID and that the
// register file, level status and indicators share CLOCK.
// Functional notes
// - condition met: jump to doubled displacement plus base
// - condition not met: fetch sequential instruction
// - negated jump takes when condition is false
// - codes 000-011 test zero, positive, negative, even
// - 100 arith less, 101 arith less-or-equal
// - 110 logical less-or-equal, 111 carry
// - invalid target raises check; indicators never change
// - count jump decrements a nonzero register
// - still nonzero after decrement: take jump
// - zero count: no decrement, fall through
// - invalid count target: check, decrement still kept
// - level exit clears current in-process flag first
// - exit weighs pending, requests, summary and level masks
// - enabled work: resume highest level at saved address
// - summary disabled: ignore requests, resume highest pending
// - nothing pending or requested: enter wait state
// - jump base is next sequential instruction address
// - level resumed by level exit runs one instruction before trace sampling; wake from wait state leaves the hold clear
// - level exit outside supervisor raises privilege check
`timescale 1ns/1ns
module jle_unit
(
	// clock and reset
	input wire logic CLOCK,
	input wire logic NRST,
	// instruction in
	input wire logic EXEC_VALID,
	output logic EXEC_READY,
	input jle_pkg::jle_instr_t EXEC_INSTR,
	input wire logic [15:0] SEQ_IAR,
	input jle_pkg::jle_ind_t INDICATORS,
	input wire logic SUPERVISOR,
	input wire logic [15:0] STORE_TOP,
	// register file
	output logic [2:0] REG_RD_SEL,
	input wire logic [15:0] REG_RD_DATA,
	output logic REG_WR_EN,
	output logic [2:0] REG_WR_SEL,
	output logic [15:0] REG_WR_DATA,
	// level state
	input jle_pkg::jle_lvl_t LEVEL_STATE,
	input wire logic SUMMARY_MASK,
	input wire logic [jle_pkg::JLE_LEVELS-1:0][15:0] LEVEL_IAR,
	// results
	output logic DONE,
	output logic JUMP_TAKEN,
	output logic [15:0] NEXT_IAR,
	output logic CHECK_ADDR,
	output logic CHECK_PRIV,
	output logic INPROC_CLR,
	output logic LEVEL_WR_EN,
	output logic [1:0] NEW_LEVEL,
	output logic WAIT_STATE,
	output logic TRACE_HOLD
);
	import jle_pkg::*;
	typedef enum logic [1:0]
	{
		ST_RUN = 2'h1,
		ST_WAIT = 2'h2
	} jle_state_t;
	jle_state_t state_reg, state_next;
	logic done_reg, done_next;
	logic taken_reg, taken_next;
	logic [15:0] iar_reg, iar_next;
	logic chk_addr_reg, chk_addr_next;
	logic chk_priv_reg, chk_priv_next;
	logic inproc_reg, inproc_next;
	logic lvl_wr_reg, lvl_wr_next;
	logic [1:0] lvl_reg, lvl_next;
	logic wr_en_reg, wr_en_next;
	logic [2:0] wr_sel_reg, wr_sel_next;
	logic [15:0] wr_data_reg, wr_data_next;
	logic trace_reg, trace_next;
	logic cond_true;
	logic [15:0] target;
	logic target_bad;
	logic [15:0] count_dec;
	logic [JLE_LEVELS-1:0] pend_left;
	logic [JLE_LEVELS-1:0] ready_lv;
	logic [JLE_LEVELS-1:0] wake_lv;
	logic [1:0] high_lv;
	logic [1:0] wake_hi;
	logic accept;
	assign accept = EXEC_VALID && (state_reg == ST_RUN);
	assign EXEC_READY = (state_reg == ST_RUN);
	assign REG_RD_SEL = EXEC_INSTR.reg_sel;
	always_comb
	begin
		case (EXEC_INSTR.cond)
			JLE_CC_ZERO: cond_true = INDICATORS.zero;
			JLE_CC_POS: cond_true = !INDICATORS.negative && !INDICATORS.zero;
			JLE_CC_NEG: cond_true = INDICATORS.negative;
			JLE_CC_EVEN: cond_true = INDICATORS.even;
			JLE_CC_ALT: cond_true = INDICATORS.negative ^ INDICATORS.overflow;
			JLE_CC_ALE: cond_true = (INDICATORS.negative ^ INDICATORS.overflow) || INDICATORS.zero;
			JLE_CC_LLE: cond_true = INDICATORS.carry || INDICATORS.zero;
			JLE_CC_CARRY: cond_true = INDICATORS.carry;
			default: cond_true = 1'b0;
		endcase
	end
	// sign-extended doubled offset on next address
	assign target = SEQ_IAR + {{7{EXEC_INSTR.disp[7]}}, EXEC_INSTR.disp, 1'b0};
	assign target_bad = (target > STORE_TOP);
	assign count_dec = REG_RD_DATA - 16'h0001;
	always_comb
	begin
		pend_left = LEVEL_STATE.pending;
		pend_left[LEVEL_STATE.current] = 1'b0;
	end
	// requests only join when summary mask enabled
	assign wake_lv = SUMMARY_MASK ? (LEVEL_STATE.request & LEVEL_STATE.level_mask) : '0;
	assign ready_lv = pend_left | wake_lv;
	// level 0 has highest priority
	always_comb
	begin
		high_lv = 2'h0;
		wake_hi = 2'h0;
		for (int i = JLE_LEVELS - 1; i >= 0; i--)
		begin
			if (ready_lv[i])
				high_lv = 2'(i);
			if (wake_lv[i])
				wake_hi = 2'(i);
		end
	end
	always_comb
	begin
		state_next = state_reg;
		done_next = 1'b0;
		taken_next = 1'b0;
		iar_next = iar_reg;
		chk_addr_next = 1'b0;
		chk_priv_next = 1'b0;
		inproc_next = 1'b0;
		lvl_wr_next = 1'b0;
		lvl_next = lvl_reg;
		wr_en_next = 1'b0;
		wr_sel_next = wr_sel_reg;
		wr_data_next = wr_data_reg;
		trace_next = trace_reg;
		case (state_reg)
			ST_RUN:
			begin
				if (accept)
				begin
					done_next = 1'b1;
					iar_next = SEQ_IAR;
					trace_next = 1'b0;
					case (EXEC_INSTR.op)
						JLE_OP_JUMP_IF_CONDITION, JLE_OP_JUMP_IF_NOT_CONDITION:
						begin
							if (cond_true ^ (EXEC_INSTR.op == JLE_OP_JUMP_IF_NOT_CONDITION))
							begin
								if (target_bad)
									chk_addr_next = 1'b1;
								else
								begin
									taken_next = 1'b1;
									iar_next = target;
								end
							end
						end
						JLE_OP_COUNT_AND_JUMP:
						begin
							if (REG_RD_DATA != 16'h0000)
							begin
								wr_en_next = 1'b1;
								wr_sel_next = EXEC_INSTR.reg_sel;
								wr_data_next = count_dec;
								if (count_dec != 16'h0000)
								begin
									if (target_bad)
										chk_addr_next = 1'b1;
									else
									begin
										taken_next = 1'b1;
										iar_next = target;
									end
								end
							end
						end
						JLE_OP_LEAVE_CURRENT_LEVEL:
						begin
							if (!SUPERVISOR)
								chk_priv_next = 1'b1;
							else
							begin
								inproc_next = 1'b1;
								if (ready_lv != '0)
								begin
									taken_next = 1'b1;
									lvl_wr_next = 1'b1;
									lvl_next = high_lv;
									iar_next = LEVEL_IAR[high_lv];
									trace_next = 1'b1;
								end
								else
									state_next = ST_WAIT;
							end
						end
						default: taken_next = 1'b0;
					endcase
				end
			end
			ST_WAIT:
			begin
				if (wake_lv != '0)
				begin
					state_next = ST_RUN;
					lvl_wr_next = 1'b1;
					lvl_next = wake_hi;
					iar_next = LEVEL_IAR[wake_hi];
					taken_next = 1'b1;
				end
			end
			default: state_next = ST_RUN;
		endcase
	end
	always_ff @(posedge CLOCK or negedge NRST)
	begin
		if (!NRST)
		begin
			state_reg <= ST_RUN;
			done_reg <= 1'b0;
			taken_reg <= 1'b0;
			iar_reg <= JLE_RESET_IAR;
			chk_addr_reg <= 1'b0;
			chk_priv_reg <= 1'b0;
			inproc_reg <= 1'b0;
			lvl_wr_reg <= 1'b0;
			lvl_reg <= 2'h0;
			wr_en_reg <= 1'b0;
			wr_sel_reg <= 3'h0;
			wr_data_reg <= 16'h0000;
			trace_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			done_reg <= done_next;
			taken_reg <= taken_next;
			iar_reg <= iar_next;
			chk_addr_reg <= chk_addr_next;
			chk_priv_reg <= chk_priv_next;
			inproc_reg <= inproc_next;
			lvl_wr_reg <= lvl_wr_next;
			lvl_reg <= lvl_next;
			wr_en_reg <= wr_en_next;
			wr_sel_reg <= wr_sel_next;
			wr_data_reg <= wr_data_next;
			trace_reg <= trace_next;
		end
	end
	assign DONE = done_reg;
	assign JUMP_TAKEN = taken_reg;
	assign NEXT_IAR = iar_reg;
	assign CHECK_ADDR = chk_addr_reg;
	assign CHECK_PRIV = chk_priv_reg;
	assign INPROC_CLR = inproc_reg;
	assign LEVEL_WR_EN = lvl_wr_reg;
	assign NEW_LEVEL = lvl_reg;
	assign REG_WR_EN = wr_en_reg;
	assign REG_WR_SEL = wr_sel_reg;
	assign REG_WR_DATA = wr_data_reg;
	assign WAIT_STATE = (state_reg == ST_WAIT);
	assign TRACE_HOLD = trace_reg;
	logic is_cj;
	assign is_cj = accept && (EXEC_INSTR.op == JLE_OP_COUNT_AND_JUMP);
	jump_target_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		accept && EXEC_INSTR.op == JLE_OP_JUMP_IF_CONDITION && cond_true && !target_bad
		|=> JUMP_TAKEN && NEXT_IAR == $past(target))
		else $error("taken jump address wrong");
	fall_through_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		accept && EXEC_INSTR.op == JLE_OP_JUMP_IF_CONDITION && !cond_true
		|=> !JUMP_TAKEN && NEXT_IAR == $past(SEQ_IAR))
		else $error("untaken jump changed flow");
	negated_jump_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		accept && EXEC_INSTR.op == JLE_OP_JUMP_IF_NOT_CONDITION
		|=> JUMP_TAKEN == (!$past(cond_true) && !$past(target_bad)))
		else $error("negated jump wrong");
	addr_check_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		accept && EXEC_INSTR.op != JLE_OP_LEAVE_CURRENT_LEVEL && target_bad
		|=> !JUMP_TAKEN)
		else $error("bad target jumped");
	count_dec_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		is_cj && REG_RD_DATA != 16'h0000
		|=> REG_WR_EN && REG_WR_DATA == $past(REG_RD_DATA) - 16'h0001)
		else $error("count not decremented");
	count_zero_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		is_cj && REG_RD_DATA == 16'h0000 |=> !REG_WR_EN && !JUMP_TAKEN)
		else $error("zero count altered");
	count_last_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		is_cj && REG_RD_DATA == 16'h0001 |=> !JUMP_TAKEN && REG_WR_EN)
		else $error("jump on final count");
	level_priv_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		accept && EXEC_INSTR.op == JLE_OP_LEAVE_CURRENT_LEVEL && !SUPERVISOR
		|=> CHECK_PRIV && !INPROC_CLR && !LEVEL_WR_EN)
		else $error("privilege not checked");
	level_wait_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		accept && EXEC_INSTR.op == JLE_OP_LEAVE_CURRENT_LEVEL && SUPERVISOR
		&& ready_lv == '0 |=> WAIT_STATE && !EXEC_READY)
		else $error("no wait state");
	// a further level exit that resumes a level rearms the hold
	trace_one_a: assert property (@(posedge CLOCK) disable iff (!NRST)
		TRACE_HOLD && accept && EXEC_INSTR.op != JLE_OP_LEAVE_CURRENT_LEVEL
		|=> !TRACE_HOLD)
		else $error("trace hold too long");
	cov_taken_c: cover property (@(posedge CLOCK) disable iff (!NRST)
		JUMP_TAKEN && DONE);
	cov_wait_c: cover property (@(posedge CLOCK) disable iff (!NRST)
		WAIT_STATE ##1 !WAIT_STATE);
	cov_check_c: cover property (@(posedge CLOCK) disable iff (!NRST)
		CHECK_ADDR && REG_WR_EN);
endmodule

// file: testbench/jle_unit_test.sv
// jle_unit_test: self-checking bench for the jump and level exit unit.
// assumes jle_pkg compiled first; the unit's own assertions run alongside.
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module jle_unit_test;
	import jle_pkg::*;
	logic clk, nrst, valid, sup, summary;
	logic ready, wr_en, done, taken, chk_addr, chk_priv, inproc, lvl_wr, wait_st, trace;
	logic [2:0] rd_sel, wr_sel;
	logic [15:0] rd_data, wr_data, next_iar, seq, top;
	logic [1:0] new_lvl;
	jle_instr_t instr;
	jle_ind_t ind;
	jle_lvl_t lvl;
	logic [JLE_LEVELS-1:0][15:0] liar;
	int n_fail, n_tests;

	jle_unit dut (.CLOCK(clk), .NRST(nrst), .EXEC_VALID(valid), .EXEC_READY(ready),
		.EXEC_INSTR(instr), .SEQ_IAR(seq), .INDICATORS(ind), .SUPERVISOR(sup),
		.STORE_TOP(top), .REG_RD_SEL(rd_sel), .REG_RD_DATA(rd_data), .REG_WR_EN(wr_en),
		.REG_WR_SEL(wr_sel), .REG_WR_DATA(wr_data), .LEVEL_STATE(lvl),
		.SUMMARY_MASK(summary), .LEVEL_IAR(liar), .DONE(done), .JUMP_TAKEN(taken),
		.NEXT_IAR(next_iar), .CHECK_ADDR(chk_addr), .CHECK_PRIV(chk_priv),
		.INPROC_CLR(inproc), .LEVEL_WR_EN(lvl_wr), .NEW_LEVEL(new_lvl),
		.WAIT_STATE(wait_st), .TRACE_HOLD(trace));

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	function automatic logic [15:0] tgt(input logic [15:0] b, input logic [7:0] d);
		// doubled sign-extended word displacement
		return b + {{7{d[7]}}, d, 1'b0};
	endfunction

	function automatic logic cond_of(input int cc, input jle_ind_t v);
		case (cc)
			0: return v.zero;
			1: return !v.negative && !v.zero;
			2: return v.negative;
			3: return v.even;
			4: return v.negative ^ v.overflow;
			5: return (v.negative ^ v.overflow) || v.zero;
			6: return v.carry || v.zero;
			default: return v.carry;
		endcase
	endfunction

	// one instruction offered for one cycle; results sampled the cycle after
	task automatic exec(input jle_op_t op, input logic [2:0] cc, input logic [7:0] d);
		@(posedge clk);
		#1;
		instr.op = op;
		instr.cond = cc;
		instr.reg_sel = 3'h5;
		instr.disp = d;
		valid = 1'b1;
		@(posedge clk);
		#1;
		valid = 1'b0;
	endtask

	task automatic t_cond;
		logic c;
		logic [7:0] d;
		for (int op = 0; op < 2; op++)
			for (int cc = 0; cc < 8; cc++)
				for (int i = 0; i < 32; i++)
				begin
					ind = jle_ind_t'(i[4:0]);
					d = i[0] ? 8'h81 : 8'h7f;
					c = cond_of(cc, ind) ^ op[0];
					exec(jle_op_t'(op[1:0]), cc[2:0], d);
					`CHK(done, 1'b1)
					`CHK(taken, c)
					`CHK(next_iar, c ? tgt(seq, d) : seq)
					`CHK(chk_addr, 1'b0)
				end
	endtask

	task automatic t_bad_jump;
		top = 16'h4000;
		ind = '0;
		ind.zero = 1'b1;
		exec(JLE_OP_JUMP_IF_CONDITION, JLE_CC_ZERO, 8'h10);
		`CHK(chk_addr, 1'b1)
		`CHK(taken, 1'b0)
		`CHK(next_iar, seq)
		top = 16'hffff;
	endtask

	task automatic t_count(input logic [15:0] rv, input logic [15:0] tp);
		logic bad;
		top = tp;
		rd_data = rv;
		bad = tgt(seq, 8'h04) > tp;
		exec(JLE_OP_COUNT_AND_JUMP, 3'h0, 8'h04);
		`CHK(rd_sel, 3'h5)
		`CHK(wr_en, rv != 16'h0000)
		if (rv != 16'h0000)
		begin
			`CHK(wr_data, rv - 16'h0001)
			`CHK(wr_sel, 3'h5)
		end
		`CHK(taken, rv > 16'h0001 && !bad)
		`CHK(chk_addr, rv > 16'h0001 && bad)
		`CHK(next_iar, (rv > 16'h0001 && !bad) ? tgt(seq, 8'h04) : seq)
		top = 16'hffff;
	endtask

	// e is the level expected to resume, or -1 when none resumes (the wait state when s is set)
	task automatic t_lex(input logic s, input logic [3:0] p, input logic [3:0] r,
		input logic sm, input int e);
		sup = s;
		summary = sm;
		lvl.pending = p;
		lvl.request = r;
		exec(JLE_OP_LEAVE_CURRENT_LEVEL, 3'h0, 8'h00);
		`CHK(done, 1'b1)
		`CHK(chk_priv, !s)
		`CHK(inproc, s)
		if (e >= 0)
		begin
			`CHK(lvl_wr, 1'b1)
			`CHK(taken, 1'b1)
			`CHK(new_lvl, e[1:0])
			`CHK(next_iar, liar[e])
			`CHK(trace, 1'b1)
		end
		else if (s)
		begin
			`CHK(wait_st, 1'b1)
			`CHK(ready, 1'b0)
		end
		else
			`CHK(lvl_wr, 1'b0)
	endtask

	task automatic t_wake;
		lvl.request = 4'b0100;
		summary = 1'b1;
		for (int k = 0; k < 8 && !lvl_wr; k++)
		begin
			@(posedge clk);
			#1;
		end
		`CHK(lvl_wr, 1'b1)
		`CHK(new_lvl, 2'h2)
		`CHK(taken, 1'b1)
		`CHK(next_iar, liar[2])
		`CHK(done, 1'b0)
		`CHK(wait_st, 1'b0)
		lvl.request = 4'b0000;
	endtask

	// one ordinary instruction on the resumed level ends the trace hold
	task automatic t_trace;
		ind = '0;
		exec(JLE_OP_JUMP_IF_CONDITION, JLE_CC_ZERO, 8'h02);
		`CHK(trace, 1'b0)
		`CHK(taken, 1'b0)
	endtask

	task automatic summarize;
		if (n_fail == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		#40000;
		n_fail++;
		summarize();
	end

	initial
	begin
		n_fail = 0;
		n_tests = 0;
		nrst = 1'b0;
		valid = 1'b0;
		sup = 1'b1;
		summary = 1'b1;
		instr = '0;
		ind = '0;
		seq = 16'h4000;
		top = 16'hffff;
		rd_data = 16'h0000;
		lvl = '0;
		lvl.level_mask = 4'hf;
		liar = {16'h3300, 16'h2200, 16'h1100, 16'h0a00};
		repeat (12) @(posedge clk);
		#1;
		nrst = 1'b1;
		t_cond();
		t_bad_jump();
		t_count(16'h0005, 16'hffff);
		t_count(16'h0001, 16'hffff);
		t_count(16'h0000, 16'hffff);
		t_count(16'h0005, 16'h4000);
		t_lex(1'b0, 4'b0100, 4'b0000, 1'b1, -1);
		t_lex(1'b1, 4'b0100, 4'b0000, 1'b1, 2);
		t_lex(1'b1, 4'b0100, 4'b0010, 1'b1, 1);
		// requests ignored with the summary mask off
		t_lex(1'b1, 4'b1000, 4'b0010, 1'b0, 3);
		t_trace();
		// the exiting level's own in-process flag must not win
		t_lex(1'b1, 4'b0101, 4'b0000, 1'b1, 2);
		t_lex(1'b1, 4'b0000, 4'b0000, 1'b1, -1);
		t_wake();
		summarize();
	end
endmodule
